// [rtl/ape_top.sv]
`timescale 1ns/1ns
`include "ape_cfg.svh"
module ape_top
   import ape_pkg::*;
#(
   parameter logic [15:0] EEP_BASE = `APE_EEP_BASE,
   parameter logic [15:0] EEP_SIZE = `APE_EEP_SIZE
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic cpu_req,
   input wire logic [15:0] cpu_addr,
   input wire logic page_data_wr,
   input wire logic page_dir_wr,
   input wire logic page_wr_val,
   input wire logic page_pin_in,
   input wire logic [3:0] ram_base,
   input wire logic [3:0] reg_base,
   input wire logic eep_enable,
   input wire logic irq_entry,
   input wire logic irq_exit,
   output logic page_pin_out,
   output logic page_pin_oe,
   output logic page,
   output logic [15:0] ext_addr,
   output logic ext_cs,
   output logic ram_cs,
   output logic reg_cs,
   output logic eep_cs,
   output logic settle
);

   ape_top_st_t s;
   ape_top_st_t next_s;
   ape_tgt_t tgt;
   logic [15:0] eep_off;
   logic toggled;

   ape_port_if pio ();

   // ********************************************
   // Page-select port bit
   // ********************************************
   assign pio.data_wr = page_data_wr;
   assign pio.dir_wr = page_dir_wr;
   assign pio.wr_val = page_wr_val;
   assign pio.pin_in = page_pin_in;

   ape_port_bit u_bit (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .pio(pio)
   );

   // Pin signals come straight from the port flops
   assign page_pin_out = pio.pin_out;
   assign page_pin_oe = pio.pin_oe;

   // ********************************************
   // Address decode
   // ********************************************
   always_comb begin
      eep_off = cpu_addr - EEP_BASE;
      // Registers first, then RAM, then EEPROM, then external memory
      if (!cpu_req) begin
         tgt = APE_TGT_NONE;
      end else if (cpu_addr[15:12] == reg_base && cpu_addr[11:0] < `APE_REG_SIZE) begin
         tgt = APE_TGT_REG;
      end else if (cpu_addr[15:12] == ram_base && cpu_addr[11:0] < `APE_RAM_SIZE) begin
         tgt = APE_TGT_RAM;
      end else if (eep_enable && eep_off < EEP_SIZE) begin
         tgt = APE_TGT_EEP;
      end else begin
         tgt = APE_TGT_EXT;
      end
   end

   assign toggled = pio.level != s.page;

   // ********************************************
   // Next state
   // ********************************************
   always_comb begin
      next_s = s;
      // Page takes the pin level one clock late, registered with the fetch address
      next_s.page = pio.level;
      next_s.ext_addr = cpu_addr;
      next_s.ext_cs = tgt == APE_TGT_EXT;
      next_s.ram_cs = tgt == APE_TGT_RAM;
      next_s.reg_cs = tgt == APE_TGT_REG;
      next_s.eep_cs = tgt == APE_TGT_EEP;
      // An irq pulse arms a mark; the first page change after it
      // loads the cross-page penalty, which then drains once a cycle
      if (s.settle_cnt != 5'h00) begin
         next_s.settle_cnt = s.settle_cnt - 5'h01;
      end
      if (toggled && s.pend_entry) begin
         next_s.settle_cnt = `APE_ENTRY_EXTRA;
         next_s.pend_entry = 1'b0;
      end else if (toggled && s.pend_exit) begin
         next_s.settle_cnt = `APE_EXIT_EXTRA;
         next_s.pend_exit = 1'b0;
      end
      if (irq_entry) begin
         next_s.pend_entry = 1'b1;
         next_s.pend_exit = 1'b0;
      end else if (irq_exit) begin
         next_s.pend_exit = 1'b1;
         next_s.pend_entry = 1'b0;
      end
      next_s.settle = next_s.settle_cnt != 5'h00;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s.ext_addr <= 16'h0000;
         s.ext_cs <= 1'b0;
         s.ram_cs <= 1'b0;
         s.reg_cs <= 1'b0;
         s.eep_cs <= 1'b0;
         s.page <= `APE_PAGE_RST;
         s.pend_entry <= 1'b0;
         s.pend_exit <= 1'b0;
         s.settle_cnt <= 5'h00;
         s.settle <= 1'b0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign page = s.page;
   assign ext_addr = s.ext_addr;
   assign ext_cs = s.ext_cs;
   assign ram_cs = s.ram_cs;
   assign reg_cs = s.reg_cs;
   assign eep_cs = s.eep_cs;
   assign settle = s.settle;

   // ********************************************
   // Checks
   // ********************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   a_pullup_page_high: assert property ((ce && !pio.pin_oe && page_pin_in) |=> page)
      else $error("undriven page pin did not select the high page");
   a_page_follows_data: assert property ((ce && pio.pin_oe) |=> page == $past(pio.pin_out))
      else $error("page did not follow the driven pin");
   a_ext_fetch_addr: assert property ((ce && tgt == APE_TGT_EXT) |=> ext_cs && ext_addr == $past(cpu_addr))
      else $error("external fetch not passed through");
   a_ram_both_pages: assert property ((ce && tgt == APE_TGT_RAM) |=> ram_cs && !ext_cs)
      else $error("internal RAM lost to external memory");
   a_internal_wins: assert property ((ce && cpu_req && cpu_addr[15:12] == reg_base
      && cpu_addr[11:0] < `APE_REG_SIZE) |=> reg_cs && !ext_cs && !ram_cs)
      else $error("registers did not take priority");
   a_eep_gated: assert property ((ce && !eep_enable) |=> !eep_cs)
      else $error("disabled EEPROM selected");
   a_entry_latency: assert property ((ce && s.pend_entry && toggled) |=> s.settle_cnt == `APE_ENTRY_EXTRA)
      else $error("entry penalty not loaded");
   a_exit_latency: assert property ((ce && !s.pend_entry && s.pend_exit && toggled)
      |=> s.settle_cnt == `APE_EXIT_EXTRA)
      else $error("exit penalty not loaded");
   a_settle_drain: assert property ((ce && settle && s.settle_cnt == 5'h01 && !toggled) |=> !settle)
      else $error("settle outlived its count");
   a_idle_no_select: assert property ((ce && !cpu_req) |=> !(ext_cs || ram_cs || reg_cs || eep_cs))
      else $error("select raised without a request");
   a_one_select: assert property (ce |=> $onehot0({ext_cs, ram_cs, reg_cs, eep_cs}))
      else $error("more than one target selected");
   a_ext_addr_any: assert property (ce |=> ext_addr == $past(cpu_addr))
      else $error("external address did not follow the bus");
   // RAM answers in either page unless the register window covers it
   a_ram_window: assert property ((ce && cpu_req && cpu_addr[15:12] == ram_base && cpu_addr[11:0] < `APE_RAM_SIZE
      && cpu_addr[15:12] != reg_base) |=> ram_cs && !ext_cs)
      else $error("internal RAM window not selected");
   a_eep_over_ext: assert property ((ce && cpu_req && eep_enable && eep_off < EEP_SIZE
      && cpu_addr[15:12] != reg_base && cpu_addr[15:12] != ram_base) |=> eep_cs && !ext_cs)
      else $error("enabled EEPROM lost to external memory");

   // ********************************************
   // Page and latency checks
   // ********************************************
   a_page_holds: assert property ((ce && !toggled) |=> $stable(page))
      else $error("page moved without a pin change");
   a_freeze_hold: assert property (!ce |=> $stable({page, settle, ext_addr, ext_cs, ram_cs, reg_cs, eep_cs}))
      else $error("outputs moved while the clock enable was low");
   a_entry_marks: assert property ((ce && irq_entry) |=> s.pend_entry && !s.pend_exit)
      else $error("interrupt entry not marked");
   a_exit_marks: assert property ((ce && irq_exit && !irq_entry) |=> s.pend_exit && !s.pend_entry)
      else $error("interrupt exit not marked");
   // A mark is spent on the first page change, so a second change costs nothing
   a_pend_consumed: assert property ((ce && s.pend_entry && toggled && !irq_entry) |=> !s.pend_entry)
      else $error("entry mark survived a page change");
   a_exit_consumed: assert property ((ce && !s.pend_entry && s.pend_exit && toggled && !irq_exit)
      |=> !s.pend_exit)
      else $error("exit mark survived a page change");
   a_settle_counts: assert property ((ce && s.settle_cnt > 5'h01) |=> settle)
      else $error("settle dropped before the count ran out");
   a_settle_quiet: assert property ((ce && !s.pend_entry && !s.pend_exit && s.settle_cnt == 5'h00)
      |=> !settle)
      else $error("settle raised without a pending interrupt");

   c_page_switch: cover property (ce && pio.pin_oe && toggled);
   c_entry_cross: cover property (ce && s.pend_entry && toggled);
   c_exit_cross: cover property (ce && s.pend_exit && toggled);
   c_ram_fetch: cover property (ce && tgt == APE_TGT_RAM && !page);

endmodule

// [rtl/ape_cfg.svh]
`ifndef APE_CFG_SVH
`define APE_CFG_SVH

// ********************************************
// Reset values
// ********************************************
`define APE_DATA_RST 1'b0
`define APE_DIR_RST 1'b0
`define APE_PAGE_RST 1'b1
`define APE_RAM_BASE_RST 4'h0
`define APE_REG_BASE_RST 4'h1

// ********************************************
// Internal resource windows
// ********************************************
`define APE_RAM_SIZE 12'h200
`define APE_REG_SIZE 12'h080
`define APE_EEP_BASE 16'hb600
`define APE_EEP_SIZE 16'h0200

// ********************************************
// Cross-page latency in processor cycles
// ********************************************
`define APE_ENTRY_EXTRA 5'h15
`define APE_EXIT_EXTRA 5'h12

`endif

// [rtl/ape_pkg.sv]
package ape_pkg;

   typedef struct packed {
      logic data;
      logic dir;
   } ape_bit_st_t;

   typedef enum logic [2:0] {
      APE_TGT_NONE = 3'b000,
      APE_TGT_EXT = 3'b001,
      APE_TGT_RAM = 3'b010,
      APE_TGT_REG = 3'b011,
      APE_TGT_EEP = 3'b100
   } ape_tgt_t;

   typedef struct packed {
      logic [15:0] ext_addr;
      logic ext_cs;
      logic ram_cs;
      logic reg_cs;
      logic eep_cs;
      logic page;
      logic pend_entry;
      logic pend_exit;
      logic [4:0] settle_cnt;
      logic settle;
   } ape_top_st_t;

endpackage

// [rtl/ape_port_if.sv]
`timescale 1ns/1ns
interface ape_port_if;
   logic data_wr;
   logic dir_wr;
   logic wr_val;
   logic pin_in;
   logic pin_out;
   logic pin_oe;
   logic level;

   modport ctl (output data_wr, output dir_wr, output wr_val, output pin_in,
                input pin_out, input pin_oe, input level);
   modport bit_side (input data_wr, input dir_wr, input wr_val, input pin_in,
                     output pin_out, output pin_oe, output level);
endinterface

// [rtl/ape_port_bit.sv]
`timescale 1ns/1ns
`include "ape_cfg.svh"
module ape_port_bit
   import ape_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   ape_port_if.bit_side pio
);

   ape_bit_st_t s;
   ape_bit_st_t next_s;

   // ********************************************
   // Port data and direction bits
   // ********************************************
   always_comb begin
      next_s = s;
      if (pio.data_wr) begin
         next_s.data = pio.wr_val;
      end
      if (pio.dir_wr) begin
         next_s.dir = pio.wr_val;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s.data <= `APE_DATA_RST;
         s.dir <= `APE_DIR_RST;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign pio.pin_out = s.data;
   assign pio.pin_oe = s.dir;
   // Undriven line reads the pull-up through pin_in
   assign pio.level = s.dir ? s.data : pio.pin_in;

   // ********************************************
   // Checks
   // ********************************************
   a_input_after_reset: assert property (@(posedge clk) $rose(rstn) |-> !pio.pin_oe)
      else $error("page pin driven right after reset");
   a_data_write_lands: assert property (@(posedge clk) disable iff (!rstn)
      (ce && pio.data_wr) |=> pio.pin_out == $past(pio.wr_val))
      else $error("data write not seen on pin");
   c_turn_output: cover property (@(posedge clk) disable iff (!rstn)
      (ce && pio.dir_wr && pio.wr_val && pio.pin_out));

endmodule

// [verification/ape_eprom_model.sv]
`timescale 1ns/1ns
// ****************************************
// External program memory, two 64K halves
// ****************************************
module ape_eprom_model
   import ape_pkg::*;
(
   input wire logic clk,
   input wire logic a16,
   input wire logic [15:0] addr,
   input wire logic cs,
   output logic [7:0] data
);
   logic [7:0] last = 8'h00;
   // Deselected bus shows the inverse of the last byte driven
   always @(posedge clk) begin
      if (cs) begin
         last <= data;
      end
   end
   always_comb begin
      data = cs ? {a16, addr[6:0]} : ~last;
   end
endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ns
module tb_top
   import ape_pkg::*;
;
   logic clk = 0, rstn = 0, ce = 1, cpu_req = 0, data_wr = 0, dir_wr = 0, wr_val = 0;
   logic eep_en = 1, irq_entry = 0, irq_exit = 0;
   logic [15:0] cpu_addr = 16'h0000;
   logic [3:0] ram_base = 4'h0, reg_base = 4'h1;
   logic pin_out, pin_oe, page, ext_cs, ram_cs, reg_cs, eep_cs, settle;
   logic [15:0] ext_addr;
   logic [7:0] rom;
   wire logic pin_wire = pin_oe ? pin_out : 1'b1;
   int mismatches = 0, comparisons = 0;
   // Address and expected selects: ext, ram, reg, eep
   logic [19:0] rows [10] = '{20'h00004, 20'h01ff4, 20'h02008, 20'h10002, 20'h107f2,
                              20'h10808, 20'hb5ff8, 20'hb6001, 20'hb7ff1, 20'hb8008};
   always #4 clk = ~clk;
   ape_top dut (.clk(clk), .rstn(rstn), .ce(ce), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
      .page_data_wr(data_wr), .page_dir_wr(dir_wr), .page_wr_val(wr_val), .page_pin_in(pin_wire),
      .ram_base(ram_base), .reg_base(reg_base), .eep_enable(eep_en), .irq_entry(irq_entry),
      .irq_exit(irq_exit), .page_pin_out(pin_out), .page_pin_oe(pin_oe), .page(page),
      .ext_addr(ext_addr), .ext_cs(ext_cs), .ram_cs(ram_cs), .reg_cs(reg_cs), .eep_cs(eep_cs),
      .settle(settle));
   ape_eprom_model mem (.clk(clk), .a16(pin_wire), .addr(ext_addr), .cs(ext_cs), .data(rom));
   // ****************************************
   // Checks and bus tasks
   // ****************************************
   task wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Request stays up between accesses; idle drops it for a cycle
   task access(input logic [15:0] a);
      cpu_addr = a;
      cpu_req = 1;
      @(negedge clk);
   endtask
   task idle();
      cpu_req = 0;
      @(negedge clk);
   endtask
   task pin_wr(input logic is_data, input logic v);
      data_wr = is_data;
      dir_wr = !is_data;
      wr_val = v;
      @(negedge clk);
      data_wr = 0;
      dir_wr = 0;
   endtask
   task pulse(input logic entry);
      irq_entry = entry;
      irq_exit = !entry;
      @(negedge clk);
      irq_entry = 0;
      irq_exit = 0;
   endtask
   task settle_len(input int expn);
      int n, t;
      n = 0;
      t = 0;
      while (settle !== 1'b1 && t < 8) begin
         @(negedge clk);
         t++;
      end
      while (settle === 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk_vec("settle_cycles", expn[15:0], n[15:0]);
      if (n == 40 || (t == 8 && expn > 0))
         wrap_up();
   endtask
   function automatic logic [15:0] sel();
      return {12'h000, ext_cs, ram_cs, reg_cs, eep_cs};
   endfunction
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (8) @(negedge clk);
      chk_vec("reset_state", 16'h0004, {page_state()});
      rstn = 1;
      pin_wr(1, 1);
      @(negedge clk);
      pin_wr(0, 1);
      @(negedge clk);
      chk_vec("driven_high", 16'h0007, {page_state()});
      foreach (rows[i]) begin
         access(rows[i][19:4]);
         chk_vec("select", {12'h000, rows[i][3:0]}, sel());
         if (rows[i][3])
            chk_vec("ext_addr", rows[i][19:4], ext_addr);
      end
      idle();
      chk_vec("idle", 16'h0000, sel());
      access(16'h4005);
      chk_vec("rom_page1", 16'h0085, {8'h00, rom});
      ce = 0;
      access(16'h0100);
      chk_vec("frozen", 16'h0008, sel());
      ce = 1;
      pulse(1);
      pin_wr(1, 0);
      chk_vec("pin_then_page", 16'h0006, {page_state()});
      @(negedge clk);
      chk_vec("page_zero", 16'h0012, {page_state()});
      settle_len(21);
      access(16'h4005);
      chk_vec("rom_page0", 16'h0005, {8'h00, rom});
      access(16'h0100);
      chk_vec("ram_page0", 16'h0004, sel());
      pulse(0);
      settle_len(0);
      pin_wr(1, 1);
      settle_len(18);
      pin_wr(1, 0);
      settle_len(0);
      eep_en = 0;
      access(16'hb600);
      chk_vec("eep_off", 16'h0008, sel());
      reg_base = 4'h0;
      access(16'h0000);
      chk_vec("reg_over_ram", 16'h0002, sel());
      rstn = 0;
      @(negedge clk);
      chk_vec("mid_reset", 16'h0004, {page_state()});
      rstn = 1;
      @(negedge clk);
      chk_vec("after_reset", 16'h0004, {page_state()});
      wrap_up();
   end
   function automatic logic [15:0] page_state();
      return {13'h0000, page, pin_oe, pin_out} | {13'h0000, 1'b0, 1'b0, 1'b0} | {11'h000, settle, 4'h0};
   endfunction
endmodule
